/* shared/diag_map.vh */
// constants for the transceiver diagnostic register block
// assumes a 200 MHz system clock and a two-wire host bus of at most 100 kHz
`ifndef DIAG_MAP_VH
`define DIAG_MAP_VH

// system clock
`define CLK_KHZ          200000

// two-wire device selects (7-bit)
`define DEV_ID_PAGE      7'h50
`define DEV_DIAG_PAGE    7'h51

// identification page offsets
`define OFS_EXT_ID_FIRST 8'h40
`define OFS_MON_TYPE     8'h5c
`define OFS_OPTIONS      8'h5d
`define OFS_DIAG_REV     8'h5e
`define OFS_EXT_CHECK    8'h5f

// diagnostic page offsets
`define OFS_THRESH_LAST  8'h37
`define OFS_MEAS_FIRST   8'h60
`define OFS_MEAS_LAST    8'h6d
`define OFS_RX_POWER     8'h68
`define OFS_CTRL_STATUS  8'h6e

// control/status byte fields
`define CS_TXDIS_STATE   7
`define CS_SOFT_TXDIS    6
`define CS_RATE_STATE    4
`define CS_SOFT_RATE     3
`define CS_FAULT         2
`define CS_LOS           1
`define CS_DATA_READY    0

// optional feature flag positions
`define OPT_ALARMS       7
`define OPT_SOFT_TXDIS   6
`define OPT_SOFT_FAULT   5
`define OPT_SOFT_LOS     4
`define OPT_SOFT_RATE    3

// reset / default values
`define OPTIONS_DEFAULT  8'hf8
`define MON_TYPE_DEFAULT 8'h68
`define DIAG_REV_DEFAULT 8'h01

// timing in milliseconds
`define T_SOFT_MS        100
`define T_INIT_MS        300
`define T_DATA_MS        1000

`endif

/* rtl/serial_line_sync.v */
// two-wire line synchroniser with edge, start and stop detection
// assumes scl and sda arrive asynchronously from the host pins
`timescale 1ns/1ps
`default_nettype none

module serial_line_sync (
  input  wire clk_in,
  input  wire nrst_in,
  input  wire scl_in,
  input  wire sda_in,
  output wire sda_level_out,
  output wire scl_rise_out,
  output wire scl_fall_out,
  output wire start_out,
  output wire stop_out
);

  reg [1:0] scl_meta;
  reg [1:0] sda_meta;
  reg       scl_q;
  reg       sda_q;

  ////////////////////////////////////////////////////////////////////
  // two flops per line, then one history stage for edges
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      scl_q    <= scl_meta[1];
      sda_q    <= sda_meta[1];
    end
  end

  // edges seen only on synchronised copies
  assign sda_level_out = sda_meta[1];
  assign scl_rise_out  = scl_meta[1] & ~scl_q;
  assign scl_fall_out  = ~scl_meta[1] & scl_q;
  assign start_out     = scl_meta[1] & scl_q & sda_q & ~sda_meta[1];
  assign stop_out      = scl_meta[1] & scl_q & ~sda_q & sda_meta[1];

endmodule
`default_nettype wire

/* rtl/transceiver_diag_soft_control.v */
// diagnostic register block of an optical transceiver on the two-wire bus
// assumes measurement words and fault/los levels come from on-chip logic
`timescale 1ns/1ps
`default_nettype none
`include "diag_map.vh"

// Behaviour
// - feature byte flags alarms, soft disable, fault, loss, rate; low bits zero
// - fault, loss, disable and rate readable or writable over the bus
// - soft disable set turns optical output off within 100 ms
// - soft disable cleared turns optical output on within 100 ms
// - after power-up or fault-clear toggle, initialise and clear fault within 300 ms
// - transmitter fault sets the soft fault bit within 100 ms
// - loss of signal sets the soft loss bit within 100 ms
// - signal return clears the soft loss bit within 100 ms
// - rate bit change sets receiver bandwidth within 100 ms
// - measurement data ready flagged in bit 0 of byte 110 within 1000 ms
// - disable and rate deadlines counted from the end of the write transaction
// - revision byte holds unsigned code, 1 means current feature set
// - live measurements served at the second device address
// - monitoring type bits 5 and 4 tell calibrated or raw values
// - each measurement is two bytes, most significant first
// - bits 6 and 3 of byte 110 always read back, act only if present
module transceiver_diag_soft_control #(
  parameter [7:0]   OPTIONS      = `OPTIONS_DEFAULT,
  parameter [7:0]   MON_TYPE     = `MON_TYPE_DEFAULT,
  parameter [7:0]   DIAG_REV     = `DIAG_REV_DEFAULT,
  parameter [223:0] EXT_ID_BYTES = 224'h0,
  parameter [31:0]  INIT_CYCLES  = `T_INIT_MS * `CLK_KHZ,
  parameter [31:0]  READY_CYCLES = `T_DATA_MS * `CLK_KHZ
) (
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_out,
  input  wire        tx_fault_cond_in,
  input  wire        receive_signal_loss_flag_cond_in,
  input  wire [15:0] temp_in,
  input  wire [15:0] supply_in,
  input  wire [15:0] bias_in,
  input  wire [15:0] tx_power_in,
  input  wire [15:0] rx_power_in,
  input  wire [15:0] aux1_in,
  input  wire [15:0] aux2_in,
  output reg         tx_disable_out,
  output reg         rate_select_out,
  output reg         tx_fault_out,
  output reg         receive_signal_loss_flag_out,
  output reg         data_ready_out
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_ACK  = 6'h04;
  localparam [5:0] ST_WR   = 6'h08;
  localparam [5:0] ST_RD   = 6'h10;
  localparam [5:0] ST_RACK = 6'h20;

  wire         sda_s;
  wire         scl_rise;
  wire         scl_fall;
  wire         bus_start;
  wire         bus_stop;
  wire [111:0] meas_all;

  reg  [5:0]  state;
  reg  [2:0]  bit_cnt;
  reg  [7:0]  shift_in;
  reg  [7:0]  shift_out;
  reg         byte_done;
  reg         is_read;
  reg         diag_page;
  reg         have_ptr;
  reg  [7:0]  ptr;
  reg  [7:0]  thresh [0:55];
  reg         soft_txdis;
  reg         soft_rate;
  reg         ctrl_written;
  reg  [1:0]  fault_meta;
  reg  [1:0]  los_meta;
  reg  [31:0] init_cnt;
  reg  [31:0] ready_cnt;
  reg  [7:0]  low_shadow;
  reg  [7:0]  shadow_ptr;
  reg         shadow_valid;
  reg  [7:0]  check_sum;
  reg  [7:0]  rd_byte;
  reg  [7:0]  meas_off;
  integer     i;
  integer     j;

  ////////////////////////////////////////////////////////////////////
  // line synchroniser and edge detector
  serial_line_sync u_sync (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .scl_in        (scl_in),
    .sda_in        (sda_in),
    .sda_level_out (sda_s),
    .scl_rise_out  (scl_rise),
    .scl_fall_out  (scl_fall),
    .start_out     (bus_start),
    .stop_out      (bus_stop)
  );

  // measurement words, field k at bits 16k, high byte above low byte
  assign meas_all = {aux2_in, aux1_in, rx_power_in, tx_power_in,
                     bias_in, supply_in, temp_in};

  ////////////////////////////////////////////////////////////////////
  // check byte over bytes 64..94
  always @* begin
    check_sum = MON_TYPE + {OPTIONS[7:3], 3'h0} + DIAG_REV;
    for (j = 0; j < 28; j = j + 1) begin
      check_sum = check_sum + EXT_ID_BYTES[j*8 +: 8];
    end
  end

  // read data selection
  always @* begin
    rd_byte  = 8'h00;
    meas_off = ptr - `OFS_MEAS_FIRST;
    if (!diag_page) begin
      if (ptr >= `OFS_EXT_ID_FIRST && ptr < `OFS_MON_TYPE)
        rd_byte = EXT_ID_BYTES[{ptr[4:0], 3'h0} +: 8];
      else if (ptr == `OFS_MON_TYPE)
        rd_byte = MON_TYPE;
      else if (ptr == `OFS_OPTIONS)
        rd_byte = {OPTIONS[7:3], 3'h0};
      else if (ptr == `OFS_DIAG_REV)
        rd_byte = DIAG_REV;
      else if (ptr == `OFS_EXT_CHECK)
        rd_byte = check_sum;
    end else begin
      if (ptr <= `OFS_THRESH_LAST)
        rd_byte = thresh[ptr[5:0]];
      else if (ptr >= `OFS_MEAS_FIRST && ptr <= `OFS_MEAS_LAST) begin
        if (!meas_off[0])
          rd_byte = meas_all[{meas_off[3:1], 4'h8} +: 8];
        else if (shadow_valid && shadow_ptr == ptr)
          rd_byte = low_shadow;
        else
          rd_byte = meas_all[{meas_off[3:1], 4'h0} +: 8];
      end else if (ptr == `OFS_CTRL_STATUS) begin
        rd_byte = {tx_disable_out, soft_txdis, 1'b0, rate_select_out,
                   soft_rate, tx_fault_out, receive_signal_loss_flag_out,
                   data_ready_out};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // two-wire slave engine and register writes
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state        <= ST_IDLE;
      bit_cnt      <= 3'h0;
      shift_in     <= 8'h00;
      shift_out    <= 8'h00;
      byte_done    <= 1'b0;
      is_read      <= 1'b0;
      diag_page    <= 1'b0;
      have_ptr     <= 1'b0;
      ptr          <= 8'h00;
      sda_out      <= 1'b0;
      sda_oe_out   <= 1'b0;
      soft_txdis   <= 1'b0;
      soft_rate    <= 1'b0;
      ctrl_written <= 1'b0;
      low_shadow   <= 8'h00;
      shadow_ptr   <= 8'h00;
      shadow_valid <= 1'b0;
      for (i = 0; i < 56; i = i + 1) begin
        thresh[i] <= 8'h00;
      end
    end else if (bus_start) begin
      state      <= ST_ADDR;
      bit_cnt    <= 3'h0;
      byte_done  <= 1'b0;
      have_ptr   <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (bus_stop) begin
      state        <= ST_IDLE;
      sda_oe_out   <= 1'b0;
      ctrl_written <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        // device select byte, ack only our two pages
        ST_ADDR: begin
          if (scl_rise) begin
            shift_in  <= {shift_in[6:0], sda_s};
            bit_cnt   <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == 3'h7);
          end else if (scl_fall && byte_done) begin
            byte_done <= 1'b0;
            if (shift_in[7:1] == `DEV_ID_PAGE || shift_in[7:1] == `DEV_DIAG_PAGE) begin
              diag_page  <= (shift_in[7:1] == `DEV_DIAG_PAGE);
              is_read    <= shift_in[0];
              sda_out    <= 1'b0;
              sda_oe_out <= 1'b1;
              state      <= ST_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        // ack bit, ours or the host's; act at its falling edge
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (is_read) begin
              shift_out  <= {rd_byte[6:0], 1'b0};
              sda_out    <= rd_byte[7];
              sda_oe_out <= ~rd_byte[7];
              ptr        <= ptr + 8'h01;
              if (diag_page && ptr >= `OFS_MEAS_FIRST && ptr < `OFS_MEAS_LAST && !meas_off[0]) begin
                low_shadow   <= meas_all[{meas_off[3:1], 4'h0} +: 8];
                shadow_ptr   <= ptr + 8'h01;
                shadow_valid <= 1'b1;
              end else begin
                shadow_valid <= 1'b0;
              end
              state <= ST_RD;
            end else begin
              sda_oe_out <= 1'b0;
              state      <= ST_WR;
            end
          end
        end
        // pointer byte first, then data with auto-increment
        ST_WR: begin
          if (scl_rise) begin
            shift_in  <= {shift_in[6:0], sda_s};
            bit_cnt   <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == 3'h7);
          end else if (scl_fall && byte_done) begin
            byte_done  <= 1'b0;
            sda_out    <= 1'b0;
            sda_oe_out <= 1'b1;
            state      <= ST_ACK;
            if (!have_ptr) begin
              ptr      <= shift_in;
              have_ptr <= 1'b1;
            end else begin
              ptr <= ptr + 8'h01;
              if (diag_page && ptr <= `OFS_THRESH_LAST)
                thresh[ptr[5:0]] <= shift_in;
              if (diag_page && ptr == `OFS_CTRL_STATUS) begin
                soft_txdis   <= shift_in[`CS_SOFT_TXDIS];
                soft_rate    <= shift_in[`CS_SOFT_RATE];
                ctrl_written <= 1'b1;
              end
            end
          end
        end
        // shift data out on falling edges, open drain: drive only zeros
        ST_RD: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              sda_oe_out <= 1'b0;
              state      <= ST_RACK;
            end else begin
              sda_out    <= shift_out[7];
              sda_oe_out <= ~shift_out[7];
              shift_out  <= {shift_out[6:0], 1'b0};
            end
          end
        end
        // host ack seen at the rise: next byte leaves at this bit's fall
        ST_RACK: begin
          if (scl_rise) begin
            if (!sda_s)
              state <= ST_ACK;
            else
              state <= ST_IDLE;
          end
        end
        default: begin
          state      <= ST_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status sampling, control application and start-up timers
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_meta                   <= 2'h0;
      los_meta                     <= 2'h0;
      tx_disable_out               <= 1'b0;
      rate_select_out              <= 1'b0;
      tx_fault_out                 <= 1'b0;
      receive_signal_loss_flag_out <= 1'b0;
      init_cnt                     <= 32'h0;
      ready_cnt                    <= 32'h0;
      data_ready_out               <= 1'b0;
    end else begin
      fault_meta <= {fault_meta[0], tx_fault_cond_in};
      los_meta   <= {los_meta[0], receive_signal_loss_flag_cond_in};
      // controls take effect at the end of the write, well inside 100 ms
      if (bus_stop && ctrl_written) begin
        tx_disable_out  <= soft_txdis & OPTIONS[`OPT_SOFT_TXDIS];
        rate_select_out <= soft_rate & OPTIONS[`OPT_SOFT_RATE];
        if (tx_disable_out && !(soft_txdis & OPTIONS[`OPT_SOFT_TXDIS]))
          init_cnt <= 32'h0;
      end else if (init_cnt < INIT_CYCLES) begin
        init_cnt <= init_cnt + 32'h1;
      end
      // fault held clear while initialising, else latched
      if (init_cnt < INIT_CYCLES)
        tx_fault_out <= 1'b0;
      else if (fault_meta[1] && OPTIONS[`OPT_SOFT_FAULT])
        tx_fault_out <= 1'b1;
      receive_signal_loss_flag_out <= los_meta[1] & OPTIONS[`OPT_SOFT_LOS];
      if (ready_cnt < READY_CYCLES)
        ready_cnt <= ready_cnt + 32'h1;
      else
        data_ready_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* tb/diag_asserts.sv */
// assertion checker for the diagnostic register block
// assumes it is bound to the block top and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module diag_asserts #(
  parameter [31:0] INIT_CYCLES  = 32'd50,
  parameter [31:0] READY_CYCLES = 32'd100
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic tx_fault_cond_in,
  input wire logic receive_signal_loss_flag_cond_in,
  input wire logic tx_disable_out,
  input wire logic rate_select_out,
  input wire logic tx_fault_out,
  input wire logic receive_signal_loss_flag_out,
  input wire logic data_ready_out
);
  logic [31:0] up_cnt;
  logic [7:0]  stop_cnt;
  logic [7:0]  on_cnt;
  logic        sda_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  //////////////////////////////////////////////////
  // cycles since reset, since the last bus stop and since the laser was enabled
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_cnt   <= 32'h0;
      stop_cnt <= 8'hff;
      on_cnt   <= 8'hff;
      sda_q    <= 1'b1;
    end else begin
      up_cnt   <= up_cnt + 32'h1;
      sda_q    <= sda_in;
      stop_cnt <= (scl_in && sda_in && !sda_q) ? 8'h0 : stop_cnt + {7'h0, stop_cnt != 8'hff};
      on_cnt   <= tx_disable_out ? 8'h0 : on_cnt + {7'h0, on_cnt != 8'hff};
    end
  end

  // status, timing and control checks
  AST_LOS_SET: assert property ($rose(receive_signal_loss_flag_cond_in) |-> ##[1:4] receive_signal_loss_flag_out)
    else $error("loss flag late");
  AST_LOS_CLR: assert property ($fell(receive_signal_loss_flag_cond_in) |-> ##[1:4] !receive_signal_loss_flag_out)
    else $error("loss flag not cleared");
  AST_FAULT_SET: assert property ($rose(tx_fault_cond_in) && up_cnt > INIT_CYCLES + 32'd8 |-> ##[1:4] tx_fault_out)
    else $error("fault flag late");
  AST_FAULT_CLR: assert property ($fell(tx_fault_out) |-> on_cnt < 8'd4)
    else $error("fault cleared without enable toggle");
  AST_INIT_QUIET: assert property (up_cnt < INIT_CYCLES |-> !tx_fault_out)
    else $error("fault shown during init");
  AST_READY_EARLY: assert property (up_cnt < READY_CYCLES |-> !data_ready_out)
    else $error("data ready too early");
  AST_READY_LATE: assert property (up_cnt > READY_CYCLES + 32'd1 |-> data_ready_out)
    else $error("data ready missing");
  AST_DIS_AT_STOP: assert property ($changed(tx_disable_out) |-> stop_cnt < 8'd16)
    else $error("disable moved away from a stop");
  AST_RATE_AT_STOP: assert property ($changed(rate_select_out) |-> stop_cnt < 8'd16)
    else $error("rate moved away from a stop");
endmodule

bind transceiver_diag_soft_control diag_asserts #(
  .INIT_CYCLES(INIT_CYCLES), .READY_CYCLES(READY_CYCLES)
) diag_asserts_i (
  .clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl_in), .sda_in(sda_in),
  .tx_fault_cond_in(tx_fault_cond_in), .receive_signal_loss_flag_cond_in(receive_signal_loss_flag_cond_in),
  .tx_disable_out(tx_disable_out), .rate_select_out(rate_select_out), .tx_fault_out(tx_fault_out),
  .receive_signal_loss_flag_out(receive_signal_loss_flag_out), .data_ready_out(data_ready_out)
);
`default_nettype wire

/* tb/host_model.sv */
// two-wire host controller model driving the bus clock and data
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_oe_out
);
  // bus idles released, clock standing high
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  //////////////////////////////////////////////////
  // quarter of an 80 ns bus period
  task automatic q();
    repeat (4) @(posedge clk_in);
  endtask

  // one bit each way; data only moves while the clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_oe_out <= ~b;
    q();
    scl_out <= 1'b1;
    q();
    r = sda_in;
    q();
    scl_out <= 1'b0;
    q();
  endtask

  // start when data falls under a high clock, stop when it rises
  task automatic frame(input logic is_start);
    sda_oe_out <= !is_start;
    q();
    scl_out <= 1'b1;
    q();
    sda_oe_out <= is_start;
    q();
    if (is_start) begin
      scl_out <= 1'b0;
      q();
    end
  endtask

  // byte out, then the device acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // byte in; acknowledged unless last, so a field stays in one read
  task automatic rbyte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule
`default_nettype wire

/* tb/test_transceiver_diag_soft_control.sv */
// self-checking bench for the diagnostic register block
// assumes host_model as bus partner and diag_asserts bound to the block
`timescale 1ns/1ps
`default_nettype none
`include "diag_map.vh"
`define CHECK(g, e) check_eq(g, e)

module test_transceiver_diag_soft_control;
  logic        clk_in, nrst_in, scl, host_oe, dut_sda, dut_oe, fault_c, los_c, a;
  logic        dis, rate, fault, los, ready;
  logic [7:0]  b, c;
  logic [15:0] meas [7];
  logic [31:0] d;
  wire         sda_line;
  int          err_total, n_compared, cycles;

  // open-drain data line with pull-up
  assign sda_line = !(host_oe || (dut_oe && !dut_sda));

  host_model host_model_i (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(host_oe));

  transceiver_diag_soft_control #(
    .EXT_ID_BYTES({28{8'h11}}), .INIT_CYCLES(32'd50), .READY_CYCLES(32'd100)
  ) transceiver_diag_soft_control_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(dut_sda),
    .sda_oe_out(dut_oe), .tx_fault_cond_in(fault_c), .receive_signal_loss_flag_cond_in(los_c), .temp_in(meas[0]),
    .supply_in(meas[1]), .bias_in(meas[2]), .tx_power_in(meas[3]), .rx_power_in(meas[4]),
    .aux1_in(meas[5]), .aux2_in(meas[6]), .tx_disable_out(dis), .rate_select_out(rate),
    .tx_fault_out(fault), .receive_signal_loss_flag_out(los), .data_ready_out(ready)
  );

  //////////////////////////////////////////////////
  // compare and count
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic final_report();
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // pointer write then n bytes read in one transaction
  task automatic xfer_rd(input logic [6:0] dev, input logic [7:0] ofs, input int n, output logic [31:0] v);
    logic a0, a1, a2;
    v = 32'h0;
    host_model_i.frame(1'b1);
    host_model_i.wbyte({dev, 1'b0}, a0);
    host_model_i.wbyte(ofs, a1);
    host_model_i.frame(1'b1);
    host_model_i.wbyte({dev, 1'b1}, a2);
    for (int i = 0; i < n; i++) begin
      host_model_i.rbyte(b, i == n - 1);
      v = {v[23:0], b};
    end
    host_model_i.frame(1'b0);
    `CHECK({a0, a1, a2}, 3'b111);
  endtask

  // single byte write
  task automatic reg_wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] v);
    logic a0, a1, a2;
    host_model_i.frame(1'b1);
    host_model_i.wbyte({dev, 1'b0}, a0);
    host_model_i.wbyte(ofs, a1);
    host_model_i.wbyte(v, a2);
    host_model_i.frame(1'b0);
    `CHECK({a0, a1, a2}, 3'b111);
  endtask

  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // hang guard
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      final_report();
    end
  end

  // reset, then the register and status walk
  initial begin
    err_total  = 0;
    n_compared = 0;
    nrst_in    = 1'b0;
    fault_c    = 1'b0;
    los_c      = 1'b0;
    for (int i = 0; i < 7; i++) meas[i] = 16'h8001 + 16'(i) * 16'h1111;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    xfer_rd(`DEV_ID_PAGE, `OFS_MON_TYPE, 4, d);
    `CHECK(d[31:24], `MON_TYPE_DEFAULT);
    `CHECK(d[23:16], `OPTIONS_DEFAULT);
    `CHECK(d[15:8], `DIAG_REV_DEFAULT);
    `CHECK(d[7:0], 8'(28 * 32'h11 + `MON_TYPE_DEFAULT + `OPTIONS_DEFAULT + `DIAG_REV_DEFAULT));
    host_model_i.frame(1'b1);
    host_model_i.wbyte(8'ha4, a);
    host_model_i.frame(1'b0);
    `CHECK(a, 1'b0);
    // every field twice, the second pass with all measurement inputs inverted
    for (int k = 0; k < 14; k++) begin
      if (k == 7) for (int m = 0; m < 7; m++) meas[m] <= ~meas[m];
      xfer_rd(`DEV_DIAG_PAGE, `OFS_MEAS_FIRST + 8'(2 * (k % 7)), 2, d);
      `CHECK(d, meas[k % 7]);
    end
    // live value moves between the two halves of one read
    host_model_i.frame(1'b1);
    host_model_i.wbyte({`DEV_DIAG_PAGE, 1'b0}, a);
    host_model_i.wbyte(`OFS_RX_POWER, a);
    host_model_i.frame(1'b1);
    host_model_i.wbyte({`DEV_DIAG_PAGE, 1'b1}, a);
    host_model_i.rbyte(c, 1'b0);
    meas[4] <= 16'habcd;
    host_model_i.rbyte(b, 1'b1);
    host_model_i.frame(1'b0);
    `CHECK({c, b}, 16'h3bba);
    xfer_rd(`DEV_DIAG_PAGE, `OFS_RX_POWER + 8'h1, 1, d);
    `CHECK(d, 32'hcd);
    // status inputs and soft controls
    los_c   <= 1'b1;
    fault_c <= 1'b1;
    repeat (5) @(posedge clk_in);
    `CHECK(los, 1'b1);
    `CHECK(fault, 1'b1);
    fault_c <= 1'b0;
    reg_wr(`DEV_DIAG_PAGE, `OFS_CTRL_STATUS, 8'h48);
    repeat (4) @(posedge clk_in);
    `CHECK(dis, 1'b1);
    `CHECK(rate, 1'b1);
    `CHECK(ready, 1'b1);
    xfer_rd(`DEV_DIAG_PAGE, `OFS_CTRL_STATUS, 1, d);
    `CHECK(d, 32'hdf);
    reg_wr(`DEV_DIAG_PAGE, `OFS_CTRL_STATUS, 8'h00);
    repeat (4) @(posedge clk_in);
    `CHECK(dis, 1'b0);
    `CHECK(rate, 1'b0);
    `CHECK(fault, 1'b0);
    los_c <= 1'b0;
    repeat (5) @(posedge clk_in);
    `CHECK(los, 1'b0);
    xfer_rd(`DEV_DIAG_PAGE, `OFS_CTRL_STATUS, 1, d);
    `CHECK(d, 32'h01);
    reg_wr(`DEV_DIAG_PAGE, 8'h10, 8'h5a);
    xfer_rd(`DEV_DIAG_PAGE, 8'h10, 1, d);
    `CHECK(d, 32'h5a);
    final_report();
  end
endmodule
`default_nettype wire
